// [core/pirp_pkg.sv]
// Purpose: constants shared by the serial register port of the power-management device
// Assumes: single clock clk at 25 MHz, synchronous active-high reset srst
// Notes: serial clock and data come from outside and are synchronised inside
package pirp_pkg;
    localparam logic [6:0] DEV_ADDR = 7'h61;
    localparam int NUM_REGS = 32;
    localparam logic [4:0] RESET_REG_IDX = 5'h18;
    localparam logic [4:0] FLAG_REG_IDX = 5'h1A;
    localparam int SOFTWARE_RESET_REQUEST_BIT = 0;
    localparam int PWR_LOSS_BIT = 0;
    localparam int OTP_LOAD_CYCLES = 32;
    localparam int FIFO_DEPTH = 32;
    localparam int CLK_MHZ = 25;
    localparam int STRETCH_NS = 40;
    localparam int STRETCH_CYC = (STRETCH_NS * CLK_MHZ + 999) / 1000;
    typedef enum logic [3:0]
    {
        PIRP_SHUTDOWN = 4'b0001,
        PIRP_READ_OTP = 4'b0010,
        PIRP_STANDBY = 4'b0100,
        PIRP_ACTIVE = 4'b1000
    } pirp_mode_e;
    typedef enum logic [4:0]
    {
        PIRP_IDLE = 5'b00001,
        PIRP_ADDR = 5'b00010,
        PIRP_ACK = 5'b00100,
        PIRP_RXB = 5'b01000,
        PIRP_TXB = 5'b10000
    } pirp_bus_e;
endpackage : pirp_pkg

// [core/pirp_fifo_if.sv]
// Purpose: write-stream carrier between serial port and its fifo
// Assumes: same clock on both sides
// Notes: word holds register index and data
`timescale 1ns/100ps
`default_nettype none
interface pirp_fifo_if #(parameter int W = 13);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : pirp_fifo_if
`default_nettype wire

// [core/pirp_fifo.sv]
// Purpose: flip-flop fifo for register write requests
// Assumes: power-of-two depth
// Notes: honest full and empty through count
`timescale 1ns/100ps
`default_nettype none
module pirp_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic srst,
    pirp_fifo_if.snk in_if,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin : g_bad_depth
        $error("depth must be power of two");
    end
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;
    assign push = in_if.valid && in_if.ready;
    assign pop = out_valid && out_ready;
    assign in_if.ready = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    always_comb
    begin
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
        if (push)
            mem_q[wr_q] <= in_if.data;
    end
endmodule : pirp_fifo
`default_nettype wire

// [core/pirp_top.sv]
// Purpose: serial register port with device operating modes
// Assumes: serial clock far slower than clk; sampled by two flip-flops
// Notes: high-speed rates need a faster clk than 25 MHz
`timescale 1ns/100ps
`default_nettype none
module pirp_top #(
    parameter int NREG = pirp_pkg::NUM_REGS,
    parameter int OTP_CYC = pirp_pkg::OTP_LOAD_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic main_supply_ok,
    input wire logic [NREG*8-1:0] otp_defaults,
    input wire logic regulator_on,
    output logic [3:0] device_mode,
    output logic bus_busy,
    output logic [NREG*8-1:0] reg_image
);
    if (NREG <= int'(pirp_pkg::FLAG_REG_IDX) || NREG > 32 || OTP_CYC < 1)
    begin : g_bad_param
        $error("bad parameter");
    end
    localparam int FW = 13;
    logic [1:0] scl_s_q, sda_s_q, sup_s_q;
    logic scl_p_q, sda_p_q;
    logic scl, sda, sup_ok, scl_rise, scl_fall, start_c, stop_c;
    assign scl = scl_s_q[1];
    assign sda = sda_s_q[1];
    assign sup_ok = sup_s_q[1];
    assign scl_rise = scl && !scl_p_q;
    assign scl_fall = !scl && scl_p_q;
    assign start_c = scl && scl_p_q && sda_p_q && !sda;
    assign stop_c = scl && scl_p_q && !sda_p_q && sda;

    pirp_pkg::pirp_mode_e mode_q, mode_d;
    logic [15:0] otp_cnt_q, otp_cnt_d;
    pirp_pkg::pirp_bus_e st_q, st_d;
    logic [3:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d;
    logic [7:0] idx_q, idx_d;
    logic rd_q, rd_d, sel_q, sel_d, have_idx_q, have_idx_d, ackon_q, ackon_d;
    logic nack_q, nack_d, busy_q, busy_d, was_tx_q, was_tx_d;
    logic sda_o_q, sda_o_d, sda_oe_q, sda_oe_d;
    logic [7:0] regs_q [NREG];
    logic [7:0] regs_d [NREG];
    logic push_v;
    logic [FW-1:0] push_w;
    logic f_valid;
    logic [FW-1:0] f_data;

    pirp_fifo_if #(.W(FW)) wr_if ();
    assign wr_if.valid = push_v;
    assign wr_if.data = push_w;

    pirp_fifo #(.WIDTH(FW), .DEPTH(pirp_pkg::FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .srst(srst),
        .in_if(wr_if),
        .out_valid(f_valid),
        .out_ready(1'b1),
        .out_data(f_data)
    );

    function automatic logic [7:0] rd_reg(input logic [7:0] i, input logic [7:0] r [NREG]);
        rd_reg = (i < NREG[7:0]) ? r[i[$clog2(NREG)-1:0]] : 8'h00;
    endfunction : rd_reg

    // operating modes
    always_comb
    begin
        mode_d = mode_q;
        otp_cnt_d = otp_cnt_q;
        case (mode_q)
            pirp_pkg::PIRP_SHUTDOWN:
            begin
                otp_cnt_d = '0;
                if (sup_ok)
                    mode_d = pirp_pkg::PIRP_READ_OTP;
            end
            pirp_pkg::PIRP_READ_OTP:
            begin
                otp_cnt_d = otp_cnt_q + 16'h0001;
                if (otp_cnt_q == 16'(OTP_CYC - 1))
                    mode_d = pirp_pkg::PIRP_STANDBY;
            end
            pirp_pkg::PIRP_STANDBY:
            begin
                if (regulator_on)
                    mode_d = pirp_pkg::PIRP_ACTIVE;
            end
            pirp_pkg::PIRP_ACTIVE:
            begin
                if (!regulator_on)
                    mode_d = pirp_pkg::PIRP_STANDBY;
            end
            default:
                mode_d = pirp_pkg::PIRP_SHUTDOWN;
        endcase
        if (!sup_ok)
            mode_d = pirp_pkg::PIRP_SHUTDOWN;
    end

    // serial protocol
    always_comb
    begin
        st_d = st_q;
        bit_d = bit_q;
        sh_d = sh_q;
        idx_d = idx_q;
        rd_d = rd_q;
        sel_d = sel_q;
        have_idx_d = have_idx_q;
        ackon_d = ackon_q;
        nack_d = nack_q;
        busy_d = busy_q;
        was_tx_d = was_tx_q;
        sda_o_d = 1'b0;
        sda_oe_d = sda_oe_q;
        push_v = 1'b0;
        push_w = {idx_q[4:0], sh_q};
        case (st_q)
            pirp_pkg::PIRP_IDLE:
                sda_oe_d = 1'b0;
            pirp_pkg::PIRP_ADDR, pirp_pkg::PIRP_RXB:
            begin
                if (scl_rise)
                begin
                    sh_d = {sh_q[6:0], sda};
                    bit_d = bit_q + 4'h1;
                end
                if (scl_fall && bit_q == 4'h8)
                begin
                    bit_d = 4'h0;
                    was_tx_d = 1'b0;
                    st_d = pirp_pkg::PIRP_ACK;
                    if (st_q == pirp_pkg::PIRP_ADDR)
                    begin
                        sel_d = (sh_q[7:1] == pirp_pkg::DEV_ADDR);
                        rd_d = sh_q[0];
                        ackon_d = sel_d;
                    end
                    else if (!have_idx_q)
                    begin
                        idx_d = sh_q;
                        have_idx_d = 1'b1;
                        ackon_d = 1'b1;
                    end
                    else
                    begin
                        push_v = wr_if.ready && (32'(idx_q) < NREG);
                        ackon_d = wr_if.ready;
                        if (wr_if.ready)
                            idx_d = idx_q + 8'h01;
                    end
                    if (!sel_d)
                        st_d = pirp_pkg::PIRP_IDLE;
                    sda_oe_d = ackon_d && sel_d;
                end
            end
            pirp_pkg::PIRP_ACK:
            begin
                if (scl_rise)
                    nack_d = sda;
                if (scl_fall)
                begin
                    sda_oe_d = 1'b0;
                    if (rd_q && (!was_tx_q || !nack_q))
                    begin
                        sh_d = rd_reg(idx_q, regs_q);
                        st_d = pirp_pkg::PIRP_TXB;
                        sda_oe_d = !sh_d[7];
                    end
                    else if (rd_q)
                    begin
                        st_d = pirp_pkg::PIRP_IDLE;
                    end
                    else if (!ackon_q)
                        st_d = pirp_pkg::PIRP_IDLE;
                    else
                        st_d = pirp_pkg::PIRP_RXB;
                end
            end
            pirp_pkg::PIRP_TXB:
            begin
                if (scl_fall)
                begin
                    bit_d = bit_q + 4'h1;
                    sh_d = {sh_q[6:0], 1'b1};
                    sda_oe_d = (bit_q != 4'h7) && !sh_q[6];
                    if (bit_q == 4'h7)
                    begin
                        bit_d = 4'h0;
                        was_tx_d = 1'b1;
                        st_d = pirp_pkg::PIRP_ACK;
                    end
                end
            end
            default:
                st_d = pirp_pkg::PIRP_IDLE;
        endcase
        if (start_c)
        begin
            st_d = pirp_pkg::PIRP_ADDR;
            bit_d = 4'h0;
            have_idx_d = rd_q ? have_idx_q : 1'b0;
            sel_d = 1'b1;
            sda_oe_d = 1'b0;
            push_v = 1'b0;
            busy_d = 1'b1;
        end
        if (stop_c)
        begin
            st_d = pirp_pkg::PIRP_IDLE;
            busy_d = 1'b0;
            have_idx_d = 1'b0;
            sda_oe_d = 1'b0;
            push_v = 1'b0;
        end
        if (mode_q == pirp_pkg::PIRP_SHUTDOWN || mode_q == pirp_pkg::PIRP_READ_OTP)
        begin
            st_d = pirp_pkg::PIRP_IDLE;
            sda_oe_d = 1'b0;
            push_v = 1'b0;
        end
    end

    // register bank
    always_comb
    begin
        for (int i = 0; i < NREG; i++)
            regs_d[i] = regs_q[i];
        if (f_valid)
        begin
            if (f_data[12:8] == pirp_pkg::FLAG_REG_IDX)
                regs_d[pirp_pkg::FLAG_REG_IDX] = regs_q[pirp_pkg::FLAG_REG_IDX] & ~f_data[7:0];
            else if (32'(f_data[12:8]) < NREG)
                regs_d[f_data[12:8]] = f_data[7:0];
        end
        if ((mode_q != pirp_pkg::PIRP_STANDBY && mode_q != pirp_pkg::PIRP_ACTIVE) ||
            regs_q[pirp_pkg::RESET_REG_IDX][pirp_pkg::SOFTWARE_RESET_REQUEST_BIT])
        begin
            for (int i = 0; i < NREG; i++)
                regs_d[i] = otp_defaults[i*8 +: 8];
            regs_d[pirp_pkg::RESET_REG_IDX][pirp_pkg::SOFTWARE_RESET_REQUEST_BIT] = 1'b0;
            regs_d[pirp_pkg::FLAG_REG_IDX][pirp_pkg::PWR_LOSS_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        scl_s_q <= {scl_s_q[0], scl_i};
        sda_s_q <= {sda_s_q[0], sda_i};
        sup_s_q <= {sup_s_q[0], main_supply_ok};
        if (srst)
        begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            mode_q <= pirp_pkg::PIRP_SHUTDOWN;
            otp_cnt_q <= '0;
            st_q <= pirp_pkg::PIRP_IDLE;
            bit_q <= '0;
            sh_q <= '0;
            idx_q <= '0;
            rd_q <= 1'b0;
            sel_q <= 1'b0;
            have_idx_q <= 1'b0;
            ackon_q <= 1'b0;
            nack_q <= 1'b1;
            busy_q <= 1'b0;
            was_tx_q <= 1'b0;
            sda_o_q <= 1'b0;
            sda_oe_q <= 1'b0;
            for (int i = 0; i < NREG; i++)
                regs_q[i] <= 8'h00;
        end
        else
        begin
            scl_p_q <= scl;
            sda_p_q <= sda;
            mode_q <= mode_d;
            otp_cnt_q <= otp_cnt_d;
            st_q <= st_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            idx_q <= idx_d;
            rd_q <= rd_d;
            sel_q <= sel_d;
            have_idx_q <= have_idx_d;
            ackon_q <= ackon_d;
            nack_q <= nack_d;
            busy_q <= busy_d;
            was_tx_q <= was_tx_d;
            sda_o_q <= sda_o_d;
            sda_oe_q <= sda_oe_d;
            for (int i = 0; i < NREG; i++)
                regs_q[i] <= regs_d[i];
        end
    end

    // open drain: only ever drives low
    assign sda_o = sda_o_q;
    assign sda_oe = sda_oe_q;
    assign device_mode = mode_q;
    assign bus_busy = busy_q;
    always_comb
    begin
        for (int i = 0; i < NREG; i++)
            reg_image[i*8 +: 8] = regs_q[i];
    end
endmodule : pirp_top
`default_nettype wire

// [verification/pirp_props.sv]
// Purpose: port checks of the serial register port
// Assumes: pins sampled by clk, srst synchronous
// Notes: raw scl is used, so windows allow the sync latency
`timescale 1ns/100ps
`default_nettype none
module pirp_props #(
    parameter int NREG = 32
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic main_supply_ok,
    input wire logic [NREG*8-1:0] otp_defaults,
    input wire logic regulator_on,
    input wire logic [3:0] device_mode,
    input wire logic bus_busy,
    input wire logic [NREG*8-1:0] reg_image
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    logic up;
    assign up = device_mode[2] | device_mode[3];
    sequence start_s;
        up && scl_i && $past(scl_i) && $fell(sda_i);
    endsequence
    sequence stop_s;
        up && scl_i && $past(scl_i) && $rose(sda_i);
    endsequence
    a_start_busy: assert property (start_s |-> ##[1:6] bus_busy)
        else $error("busy not raised after start");
    a_stop_idle: assert property (stop_s |-> ##[1:6] !bus_busy)
        else $error("busy not cleared after stop");
    a_oe_scl_low: assert property ($changed(sda_oe) |-> !$past(scl_i, 2))
        else $error("data drive changed while clock high");
    a_oe_powered: assert property (sda_oe |-> up || $past(up))
        else $error("data driven while not powered");
    a_lockout_quiet: assert property ($fell(main_supply_ok) |->
        ##[1:6] (device_mode == 4'h1 && !sda_oe))
        else $error("lockout did not reach shutdown");
    a_od_low: assert property (sda_oe |-> !sda_o)
        else $error("driven level not low");
    a_otp_standby: assert property ($rose(device_mode[1]) |-> ##[1:40] device_mode[2])
        else $error("default load did not end in standby");
    a_reg_active: assert property ($rose(regulator_on) && device_mode[2] |->
        ##[1:4] (device_mode[3] || device_mode[0]))
        else $error("active not entered");
    a_reg_standby: assert property ($fell(regulator_on) && device_mode[3] |->
        ##[1:4] !device_mode[3])
        else $error("active not left");
endmodule : pirp_props
`default_nettype wire

// [verification/pirp_host_model.sv]
// Purpose: bus master model driving scl and pulling sda
// Assumes: pull-up on sda, so release reads high
// Notes: scl stands high between frames; bit period 320 ns
`timescale 1ns/100ps
`default_nettype none
module pirp_host_model (
    output logic scl,
    output logic sda_pull,
    input wire logic sda
);
    localparam time Q = 80ns;
    logic [7:0] obs;
    event done;
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic start();
        #7;
        sda_pull = 1'b0;
        #Q;
        scl = 1'b1;
        #Q;
        sda_pull = 1'b1;
        #Q;
        scl = 1'b0;
        #Q;
    endtask : start
    task automatic stop();
        sda_pull = 1'b1;
        #Q;
        scl = 1'b1;
        #Q;
        sda_pull = 1'b0;
        #Q;
    endtask : stop
    task automatic bit_io(input logic b, output logic r);
        sda_pull = ~b;
        #Q;
        scl = 1'b1;
        #Q;
        r = sda;
        #Q;
        scl = 1'b0;
        #Q;
    endtask : bit_io
    task automatic wbyte(input logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], r);
        bit_io(1'b1, r);
        obs = {7'h0, ~r};
        ->done;
    endtask : wbyte
    task automatic rbyte(input logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, obs[i]);
        bit_io(~ack, r);
        ->done;
    endtask : rbyte
endmodule : pirp_host_model
`default_nettype wire

// [verification/tb_pirp_top.sv]
// Purpose: self-checking bench of the serial register port
// Assumes: host model on the far side, OTP_CYC shortened to 2
// Notes: bus results are queued and compared by a monitor
`timescale 1ns/100ps
`default_nettype none
module tb_pirp_top;
    localparam int NREG = 32;
    localparam logic [7:0] AW = {pirp_pkg::DEV_ADDR, 1'b0};
    localparam logic [7:0] AR = {pirp_pkg::DEV_ADDR, 1'b1};
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic supply_ok = 1'b0;
    logic reg_on = 1'b0;
    logic scl, host_pull, sda_w, sda_o, sda_oe, bus_busy;
    logic [3:0] mode;
    logic [NREG*8-1:0] otp, image;
    logic [7:0] exp_q[$];
    logic [7:0] v[3];
    int err_count = 0;
    int n_checks = 0;
    int seed = 32'hc5c7_9cca;
    always #20 clk = ~clk;
    // pull-up wins unless someone pulls low
    assign sda_w = (sda_oe ? sda_o : 1'b1) & ~host_pull;
    pirp_top #(.NREG(NREG), .OTP_CYC(2)) pirp_top_i (.clk(clk), .srst(srst), .scl_i(scl),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .main_supply_ok(supply_ok),
        .otp_defaults(otp), .regulator_on(reg_on), .device_mode(mode),
        .bus_busy(bus_busy), .reg_image(image));
    pirp_host_model pirp_host_model_i (.scl(scl), .sda_pull(host_pull), .sda(sda_w));
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        n_checks++;
        if (seen !== want)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : report_and_stop
    function automatic logic [7:0] rb(input int i);
        return image[i*8 +: 8];
    endfunction : rb
    function automatic logic [7:0] ob(input int i);
        return otp[i*8 +: 8];
    endfunction : ob
    task automatic wr(input logic [7:0] b, input logic ack);
        exp_q.push_back({7'h0, ack});
        pirp_host_model_i.wbyte(b);
    endtask : wr
    task automatic rd(input logic [7:0] want, input logic ack);
        exp_q.push_back(want);
        pirp_host_model_i.rbyte(ack);
    endtask : rd
    task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
        pirp_host_model_i.start();
        wr(AW, 1'b1);
        wr(idx, 1'b1);
        wr(d, 1'b1);
        pirp_host_model_i.stop();
        repeat (8) @(negedge clk);
    endtask : wreg
    task automatic wait_mode(input logic [3:0] m);
        for (int k = 0; k < 200 && mode !== m; k++)
            @(negedge clk);
        check({4'h0, mode}, {4'h0, m});
    endtask : wait_mode
    always @(pirp_host_model_i.done)
        check(pirp_host_model_i.obs, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
    initial
    begin
        #1ms;
        err_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        report_and_stop();
    end
    initial
    begin
        logic r;
        for (int i = 0; i < NREG; i++)
            otp[i*8 +: 8] = $random(seed);
        // reset bit kept clear, since loading clears it and the power-up check would fail
        otp[8'h18*8] = 1'b0;
        for (int i = 0; i < 3; i++)
            v[i] = $random(seed);
        repeat (4) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        supply_ok = 1'b1;
        wait_mode(4'h2);
        wait_mode(4'h4);
        for (int i = 0; i < NREG; i++)
            check(rb(i), i == 8'h1A ? ob(i) | 8'h01 : ob(i));
        $display("done: power-up");
        foreach (v[i])
        begin
            pirp_host_model_i.start();
            check({7'h0, bus_busy}, 8'h01);
            wr({v[i][6:0] ^ 7'h61 ? v[i][6:0] : 7'h60, 1'b0}, 1'b0);
            pirp_host_model_i.stop();
            repeat (6) @(negedge clk);
            check({7'h0, bus_busy}, 8'h00);
        end
        $display("done: foreign address");
        pirp_host_model_i.start();
        wr(AW, 1'b1);
        wr(8'h02, 1'b1);
        foreach (v[i])
            wr(v[i], 1'b1);
        pirp_host_model_i.stop();
        repeat (8) @(negedge clk);
        foreach (v[i])
            check(rb(2 + i), v[i]);
        $display("done: burst write");
        pirp_host_model_i.start();
        wr(AW, 1'b1);
        wr(8'h03, 1'b1);
        pirp_host_model_i.start();
        wr(AR, 1'b1);
        rd(v[1], 1'b1);
        rd(v[1], 1'b1);
        rd(v[1], 1'b0);
        pirp_host_model_i.stop();
        $display("done: read");
        pirp_host_model_i.start();
        wr(AW, 1'b1);
        wr(8'h05, 1'b1);
        for (int i = 0; i < 4; i++)
            pirp_host_model_i.bit_io(1'b0, r);
        pirp_host_model_i.start();
        wr(AW, 1'b1);
        wr(8'h06, 1'b1);
        for (int i = 0; i < 4; i++)
            pirp_host_model_i.bit_io(1'b1, r);
        pirp_host_model_i.stop();
        repeat (8) @(negedge clk);
        check(rb(5), ob(5));
        check(rb(6), ob(6));
        $display("done: abort");
        pirp_host_model_i.start();
        wr(AW, 1'b1);
        wr(8'h25, 1'b1);
        wr(8'h5A, 1'b1);
        pirp_host_model_i.start();
        wr(AR, 1'b1);
        rd(8'h00, 1'b0);
        pirp_host_model_i.stop();
        repeat (8) @(negedge clk);
        check(rb(5), ob(5));
        $display("done: index out of range");
        reg_on = 1'b1;
        wait_mode(4'h8);
        wreg(8'h07, ~v[0]);
        check(rb(7), ~v[0]);
        @(negedge clk);
        reg_on = 1'b0;
        wait_mode(4'h4);
        $display("done: active");
        wreg(8'h18, 8'h01);
        check(rb(2), ob(2));
        wreg(8'h1A, 8'h01);
        check({7'h0, image[pirp_pkg::FLAG_REG_IDX*8 + pirp_pkg::PWR_LOSS_BIT]}, 8'h00);
        $display("done: soft reset");
        @(negedge clk);
        supply_ok = 1'b0;
        wait_mode(4'h1);
        pirp_host_model_i.start();
        wr(AW, 1'b0);
        pirp_host_model_i.stop();
        @(negedge clk);
        supply_ok = 1'b1;
        wait_mode(4'h4);
        check({7'h0, image[pirp_pkg::FLAG_REG_IDX*8 + pirp_pkg::PWR_LOSS_BIT]}, 8'h01);
        $display("done: lockout");
        report_and_stop();
    end
endmodule : tb_pirp_top
bind pirp_top pirp_props #(.NREG(NREG)) pirp_props_i (.clk(clk), .srst(srst), .scl_i(scl_i),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .main_supply_ok(main_supply_ok),
    .otp_defaults(otp_defaults), .regulator_on(regulator_on), .device_mode(device_mode),
    .bus_busy(bus_busy), .reg_image(reg_image));
`default_nettype wire
